// File: src/flag_guard.sv
// Break-state gating of status flag clearing for peripheral flag channels
`timescale 1ns/10ps

module flag_guard #(
   parameter int N = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_break,
   input wire logic bce,
   input wire logic [N-1:0] clr_req,
   input wire logic [N-1:0] step1,
   input wire logic [N-1:0] step2,
   output logic [N-1:0] clr_grant,
   output logic [N-1:0] two_step_clr
);

   typedef struct packed {
      logic [N-1:0] armed;
   } guard_state_t;

   guard_state_t st_ff;
   guard_state_t nxt_st;
   logic allow;

   // Clearing allowed outside break, or in break with the enable set
   assign allow = ~in_break | bce;

   // Single-step clears pass only while allowed; a granted clear is final
   assign clr_grant = clr_req & {N{allow}};

   // Second step clears only an armed flag and only while allowed
   assign two_step_clr = step2 & st_ff.armed & {N{allow}};

   // Arming survives break; it is spent by a completed second step
   always_comb begin
      nxt_st = st_ff;
      for (int i = 0; i < N; i++) begin
         if (two_step_clr[i]) begin
            nxt_st.armed[i] = 1'b0;
         end else if (step1[i] && allow) begin
            nxt_st.armed[i] = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

// File: src/reset_cause_and_break_flag_regs.sv
// Reset cause register, break flag control register, irq and APB slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "reset_cause_defs.svh"

module reset_cause_and_break_flag_regs #(
   parameter int FLAG_CH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic ext_rst_pin,
   input wire logic undervolt_in,
   input wire logic wdog_rst_pulse,
   input wire logic bad_opcode_pulse,
   input wire logic bad_addr_pulse,
   input wire logic bad_addr_fetch,
   input wire logic in_break,
   input wire logic [FLAG_CH-1:0] flag_clr_req,
   input wire logic [FLAG_CH-1:0] flag_step1,
   input wire logic [FLAG_CH-1:0] flag_step2,
   output logic [FLAG_CH-1:0] flag_clr_grant,
   output logic [FLAG_CH-1:0] flag_two_step_clr,
   output logic break_clear_enable,
   output logic core_rst_req,
   output logic irq
);

   // ****************************************
   // Declarations
   // ****************************************
   reset_cause_pkg::regs_state_t st_ff;
   reset_cause_pkg::regs_state_t nxt_st;
   reset_cause_pkg::cause_flags_t ev;
   reset_cause_pkg::cause_flags_t cause_clr;
   reset_cause_pkg::cause_flags_t irq_clr;
   reset_cause_pkg::cause_flags_t wr_flags;
   reset_cause_pkg::reg_id_t setup_id;
   reset_cause_pkg::reg_id_t acc_id;
   logic [1:0] async_lvl;
   logic pin_lvl;
   logic uv_lvl;
   logic setup_ph;
   logic acc_ph;
   logic wr_acc;
   logic rd_acc;
   logic rd_setup;
   logic lane0;

   // ****************************************
   // Functions
   // ****************************************

   // Byte address of a register index
   function automatic logic [31:0] addr_of(input logic [15:0] idx);
      addr_of = {14'h0000, idx, 2'b00};
   endfunction

   // Address decode, used in setup and access phases
   function automatic reset_cause_pkg::reg_id_t decode(input logic [31:0] a);
      if (a == addr_of(`CAUSE_IDX)) begin
         decode = reset_cause_pkg::REG_CAUSE;
      end else if (a == addr_of(`BREAK_CTRL_IDX)) begin
         decode = reset_cause_pkg::REG_BREAK;
      end else if (a == addr_of(`IRQ_STATUS_IDX)) begin
         decode = reset_cause_pkg::REG_IRQ_ST;
      end else if (a == addr_of(`IRQ_MASK_IDX)) begin
         decode = reset_cause_pkg::REG_IRQ_MASK;
      end else begin
         decode = reset_cause_pkg::REG_NONE;
      end
   endfunction

   // Place a six-flag field in the low byte of a read word
   function automatic logic [31:0] flags_word(input reset_cause_pkg::cause_flags_t f);
      flags_word = {`PAD_HIGH, f, `PAD_LOW};
   endfunction

   // Read value of a register
   function automatic logic [31:0] read_word(
      input reset_cause_pkg::reg_id_t id,
      input reset_cause_pkg::regs_state_t s
   );
      logic [31:0] w;
      w = '0;
      case (id)
         reset_cause_pkg::REG_CAUSE: begin
            w = flags_word(s.cause);
         end
         reset_cause_pkg::REG_BREAK: begin
            w[`BCE_BIT] = s.bce;
         end
         reset_cause_pkg::REG_IRQ_ST: begin
            w = flags_word(s.irq_st);
         end
         reset_cause_pkg::REG_IRQ_MASK: begin
            w = flags_word(s.irq_mask);
         end
         default: begin
            w = '0;
         end
      endcase
      read_word = w;
   endfunction

   // ****************************************
   // Asynchronous reset source inputs
   // ****************************************

   // External pin and low-voltage detector come from outside the clock
   sync3 #(
      .W(2)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({ext_rst_pin, undervolt_in}),
      .q(async_lvl)
   );

   assign pin_lvl = async_lvl[1];
   assign uv_lvl = async_lvl[0];

   // Cause events; power-on is taken only by the asynchronous reset
   always_comb begin
      ev = '0;
      ev.pin = pin_lvl & ~st_ff.pin_prev;
      ev.wdog = wdog_rst_pulse;
      ev.bad_op = bad_opcode_pulse;
      ev.bad_fetch = bad_addr_pulse & bad_addr_fetch;
      ev.uv = uv_lvl & ~st_ff.uv_prev;
   end

   // ****************************************
   // APB phase decode
   // ****************************************

   // Setup captures read data, access completes with zero wait states
   assign setup_ph = psel & ~penable;
   assign acc_ph = psel & penable;
   assign rd_setup = setup_ph & ~pwrite;
   assign wr_acc = acc_ph & pwrite;
   assign rd_acc = acc_ph & ~pwrite;
   assign lane0 = pstrb[`LANE0_STRB];
   assign setup_id = decode(paddr);
   assign acc_id = decode(paddr);
   assign wr_flags = pwdata[`CAUSE_MSB:`CAUSE_LSB];

   // Clear masks from reads and writes
   always_comb begin
      cause_clr = '0;
      irq_clr = '0;
      if (rd_acc && acc_id == reset_cause_pkg::REG_CAUSE) begin
         cause_clr = st_ff.rd_snap;
      end
      if (wr_acc && lane0 && acc_id == reset_cause_pkg::REG_IRQ_ST) begin
         irq_clr = wr_flags;
      end
   end

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pin_prev = pin_lvl;
      nxt_st.uv_prev = uv_lvl;
      nxt_st.rst_req = |ev;

      // Read data and error captured in the setup phase
      if (setup_ph) begin
         nxt_st.rdata = '0;
         nxt_st.slverr = (setup_id == reset_cause_pkg::REG_NONE);
         if (rd_setup) begin
            nxt_st.rdata = read_word(setup_id, st_ff);
         end
         if (rd_setup && setup_id == reset_cause_pkg::REG_CAUSE) begin
            nxt_st.rd_snap = st_ff.cause;
         end else begin
            nxt_st.rd_snap = '0;
         end
      end

      // Only what the read returned is cleared; a new event wins
      nxt_st.cause = (st_ff.cause & ~cause_clr) | ev;

      // Sticky irq status, write one to clear, set wins
      nxt_st.irq_st = (st_ff.irq_st & ~irq_clr) | ev;

      // Register writes
      if (wr_acc && lane0) begin
         if (acc_id == reset_cause_pkg::REG_BREAK) begin
            nxt_st.bce = pwdata[`BCE_BIT];
         end else if (acc_id == reset_cause_pkg::REG_IRQ_MASK) begin
            nxt_st.irq_mask = wr_flags;
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************

   // Power-on leaves only the power-on flag set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.cause <= `CAUSE_POR_VAL;
         st_ff.rd_snap <= `CAUSE_NONE;
         st_ff.irq_st <= `CAUSE_POR_VAL;
         st_ff.irq_mask <= `IRQ_MASK_RST;
         st_ff.bce <= `BCE_RST;
         st_ff.pin_prev <= 1'b0;
         st_ff.uv_prev <= 1'b0;
         st_ff.rst_req <= 1'b0;
         st_ff.slverr <= 1'b0;
         st_ff.rdata <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // Break flag protection
   // ****************************************
   flag_guard #(
      .N(FLAG_CH)
   ) u_guard (
      .clk(pclk),
      .rst_n(presetn),
      .in_break(in_break),
      .bce(st_ff.bce),
      .clr_req(flag_clr_req),
      .step1(flag_step1),
      .step2(flag_step2),
      .clr_grant(flag_clr_grant),
      .two_step_clr(flag_two_step_clr)
   );

   // ****************************************
   // Outputs
   // ****************************************

   // APB answer
   assign pready = acc_ph;
   assign prdata = st_ff.rdata;
   assign pslverr = acc_ph & st_ff.slverr;

   // Status and control outputs
   assign break_clear_enable = st_ff.bce;
   assign core_rst_req = st_ff.rst_req;
   assign irq = |(st_ff.irq_st & st_ff.irq_mask);

endmodule

// File: src/reset_cause_defs.svh
// Register indexes, field positions and reset values of the reset cause block
`ifndef RESET_CAUSE_DEFS_SVH
`define RESET_CAUSE_DEFS_SVH

// ****************************************
// Register indexes (byte address is four times the index)
// ****************************************
`define CAUSE_IDX 16'hFE01
`define BREAK_CTRL_IDX 16'hFE03
`define IRQ_STATUS_IDX 16'hFE04
`define IRQ_MASK_IDX 16'hFE05

// ****************************************
// Field positions
// ****************************************
`define CAUSE_LSB 2
`define CAUSE_MSB 7
`define BCE_BIT 7
`define LANE0_STRB 0

// ****************************************
// Reset values
// ****************************************
`define CAUSE_POR_VAL 6'h20
`define CAUSE_NONE 6'h00
`define IRQ_MASK_RST 6'h00
`define BCE_RST 1'b0
`define PAD_LOW 2'h0
`define PAD_HIGH 24'h000000

`endif

// File: src/reset_cause_pkg.sv
// Types shared by the reset cause and break flag control block
package reset_cause_pkg;

   // Six cause flags, power-on first; same layout for irq status and mask
   typedef struct packed {
      logic por;
      logic pin;
      logic wdog;
      logic bad_op;
      logic bad_fetch;
      logic uv;
   } cause_flags_t;

   // Register selected by an APB address
   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_CAUSE = 3'b001,
      REG_BREAK = 3'b010,
      REG_IRQ_ST = 3'b011,
      REG_IRQ_MASK = 3'b100
   } reg_id_t;

   // Complete state of the register bank
   typedef struct packed {
      cause_flags_t cause;
      cause_flags_t rd_snap;
      cause_flags_t irq_st;
      cause_flags_t irq_mask;
      logic bce;
      logic pin_prev;
      logic uv_prev;
      logic rst_req;
      logic slverr;
      logic [31:0] rdata;
   } regs_state_t;

endpackage

// File: src/sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/10ps

module sync3 #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_state_t;

   sync_state_t st_ff;
   sync_state_t nxt_st;

   // Shift chain; level follows once stages two and three agree
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.lvl[i] = st_ff.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.lvl;

endmodule

// File: tb/reset_cause_and_break_flag_regs_bench.sv
// Self-checking bench for the reset cause and break flag control block
`timescale 1ns/10ps
`include "reset_cause_defs.svh"
module reset_cause_and_break_flag_regs_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, irq, bce, rst_req, err;
   logic fetch = 1'b0;
   logic hit = 1'b0;
   logic [3:0] strb = 4'hF;
   logic in_break = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [3:0] clr = 4'h0;
   logic [3:0] s1 = 4'h0;
   logic [3:0] s2 = 4'h0;
   logic [3:0] grant, two;
   int n_errors = 0;
   int tests_run = 0;

   reset_cause_and_break_flag_regs #(.FLAG_CH(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ext_rst_pin(ev[4]), .undervolt_in(ev[0]),
      .wdog_rst_pulse(ev[3]), .bad_opcode_pulse(ev[2]), .bad_addr_pulse(ev[1]),
      .bad_addr_fetch(fetch), .in_break(in_break), .flag_clr_req(clr), .flag_step1(s1),
      .flag_step2(s2), .flag_clr_grant(grant), .flag_two_step_clr(two),
      .break_clear_enable(bce), .core_rst_req(rst_req), .irq(irq));

   // Clock
   always #4 pclk = ~pclk;

   task summarize();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, held until pready
   task apb(input logic w, input logic [15:0] ix, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, ix, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdc(input logic [15:0] ix, input logic [31:0] e, input string nm);
      apb(1'b0, ix, 32'h0);
      chk(nm, e, rd);
   endtask

   // Event source held high, then low; notes any core reset request
   task fire(input int i);
      hit = 1'b0;
      @(posedge pclk);
      ev[i] <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         @(negedge pclk);
         hit = hit | rst_req;
         @(posedge pclk);
         if (k == 7) begin
            ev[i] <= 1'b0;
         end
      end
   endtask

   task t_por();
      rdc(`CAUSE_IDX, 32'h80, "por cause");
      rdc(`CAUSE_IDX, 32'h0, "cause reread");
      rdc(`BREAK_CTRL_IDX, 32'h0, "break ctrl");
      rdc(`IRQ_MASK_IDX, 32'h0, "mask");
   endtask

   task t_causes();
      fetch <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         fire(i);
         chk("reset request", 32'h1, {31'h0, hit});
         rdc(`CAUSE_IDX, 32'h4 << i, "cause");
         rdc(`CAUSE_IDX, 32'h0, "cause cleared");
      end
      fetch <= 1'b0;
      fire(1);
      chk("data access request", 32'h0, {31'h0, hit});
      rdc(`CAUSE_IDX, 32'h0, "data access");
      fire(3);
      apb(1'b1, `CAUSE_IDX, 32'hFF);
      rdc(`CAUSE_IDX, 32'h20, "cause write");
   endtask

   task t_break();
      apb(1'b1, `BREAK_CTRL_IDX, 32'hFF);
      rdc(`BREAK_CTRL_IDX, 32'h80, "enable set");
      apb(1'b1, `BREAK_CTRL_IDX, 32'h0);
      strb <= 4'hE;
      apb(1'b1, `BREAK_CTRL_IDX, 32'h80);
      strb <= 4'hF;
      rdc(`BREAK_CTRL_IDX, 32'h0, "strobe off");
      s1 <= 4'h1;
      @(posedge pclk);
      s1 <= 4'h0;
      in_break <= 1'b1;
      clr <= 4'hF;
      s2 <= 4'h1;
      @(negedge pclk);
      chk("grant shut", 32'h0, {28'h0, grant});
      chk("two-step in break", 32'h0, {28'h0, two});
      @(posedge pclk);
      in_break <= 1'b0;
      @(negedge pclk);
      chk("two-step after", 32'h1, {28'h0, two});
      chk("grant out", 32'hF, {28'h0, grant});
      @(posedge pclk);
      s2 <= 4'h0;
      apb(1'b1, `BREAK_CTRL_IDX, 32'h80);
      in_break <= 1'b1;
      @(negedge pclk);
      chk("grant open", 32'hF, {28'h0, grant});
      @(posedge pclk);
      in_break <= 1'b0;
      clr <= 4'h0;
   endtask

   task t_irq();
      rdc(`IRQ_STATUS_IDX, 32'hFC, "status set");
      apb(1'b1, `IRQ_MASK_IDX, 32'h80);
      repeat (2) @(posedge pclk);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, `IRQ_STATUS_IDX, 32'hFC);
      rdc(`IRQ_STATUS_IDX, 32'h0, "status");
      chk("irq off", 32'h1, {31'h0, ~irq});
      apb(1'b0, 16'hFE02, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_por();
      t_causes();
      t_break();
      t_irq();
      summarize();
   end

   // Watchdog
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
endmodule

// File: tb/reset_cause_and_break_flag_regs_chk.sv
// Assertions on the reset cause and break flag control block
`timescale 1ns/10ps
`include "reset_cause_defs.svh"
module reset_cause_and_break_flag_regs_chk #(
   parameter int FLAG_CH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic wdog_rst_pulse,
   input wire logic bad_opcode_pulse,
   input wire logic in_break,
   input wire logic [FLAG_CH-1:0] flag_clr_req,
   input wire logic [FLAG_CH-1:0] flag_clr_grant,
   input wire logic [FLAG_CH-1:0] flag_two_step_clr,
   input wire logic break_clear_enable,
   input wire logic core_rst_req
);
   localparam logic [31:0] A_CAUSE = {14'h0, `CAUSE_IDX, 2'h0};
   localparam logic [31:0] A_BRK = {14'h0, `BREAK_CTRL_IDX, 2'h0};
   logic acc;
   logic wr_brk;
   // Access phase and break register write
   assign acc = psel && penable;
   assign wr_brk = acc && pwrite && pstrb[0] && paddr == A_BRK;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pready; acc |-> pready; endproperty
   a_pready: assert property (p_pready) else $error("no ready in access");
   property p_bce_rst; $rose(presetn) |-> !break_clear_enable; endproperty
   a_bce_rst: assert property (p_bce_rst) else $error("enable set at reset");
   property p_bce_wr; wr_brk |=> break_clear_enable == $past(pwdata[7]); endproperty
   a_bce_wr: assert property (p_bce_wr) else $error("enable write lost");
   property p_bce_hold; !wr_brk |=> $stable(break_clear_enable); endproperty
   a_bce_hold: assert property (p_bce_hold) else $error("enable changed");
   property p_brk_rd; acc && !pwrite && paddr == A_BRK |-> prdata[6:0] == 7'h00; endproperty
   a_brk_rd: assert property (p_brk_rd) else $error("reserved bits set");
   property p_cause_rd;
      acc && !pwrite && paddr == A_CAUSE |-> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0;
   endproperty
   a_cause_rd: assert property (p_cause_rd) else $error("cause spare bits set");
   property p_wdog; wdog_rst_pulse |=> core_rst_req; endproperty
   a_wdog: assert property (p_wdog) else $error("no reset after watchdog");
   property p_badop; bad_opcode_pulse |=> core_rst_req; endproperty
   a_badop: assert property (p_badop) else $error("no reset after bad opcode");
   property p_shut; in_break && !break_clear_enable |-> flag_clr_grant == '0; endproperty
   a_shut: assert property (p_shut) else $error("clear granted in break");
   property p_open; !in_break || break_clear_enable |-> flag_clr_grant == flag_clr_req; endproperty
   a_open: assert property (p_open) else $error("clear refused");
   property p_two; in_break && !break_clear_enable |-> flag_two_step_clr == '0; endproperty
   a_two: assert property (p_two) else $error("two-step clear in break");
   c_wdog: cover property (wdog_rst_pulse ##1 core_rst_req);
   c_shut: cover property (in_break && !break_clear_enable && flag_clr_req != '0);
   c_wr: cover property (wr_brk);
endmodule

bind reset_cause_and_break_flag_regs reset_cause_and_break_flag_regs_chk #(
   .FLAG_CH(FLAG_CH)
) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
   .prdata, .wdog_rst_pulse, .bad_opcode_pulse, .in_break, .flag_clr_req, .flag_clr_grant,
   .flag_two_step_clr, .break_clear_enable, .core_rst_req);
